// ### inc/ris_pkg.sv
/*
 * Constants for the remappable input selector: register byte offsets,
 * field positions, special selection codes and AHB-Lite encodings.
 * Assumes a 32-bit AHB-Lite bus with word-aligned registers.
 */
`default_nettype none

package ris_pkg;

    // ==========================================================
    // selection codes
    localparam int CODE_W = 7;
    localparam int PIN_CNT = 128;
    localparam int TOP_PIN = 121;
    localparam logic [CODE_W-1:0] CODE_GND = 7'h00;
    localparam logic [CODE_W-1:0] CODE_CMP = 7'h01;
    localparam logic [CODE_W-1:0] CODE_TOP = 7'h79;
    localparam logic [CODE_W-1:0] FIELD_RESET = 7'h00;

    // ==========================================================
    // routed peripheral inputs, one selection field each
    typedef enum int {
        F_EXT_IRQ2,
        F_TIMER2_CLK,
        F_SERIAL2_CLK,
        F_SERIAL2_DATA,
        F_SERIAL2_SEL,
        F_CAN_RX
    } ris_field_t;
    localparam int FIELD_CNT = 6;

    // ==========================================================
    // register map (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_EXT_IRQ2 = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TIMER2 = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SERIAL2_CD = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SERIAL2_SS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CAN_RX = 8'h10;
    localparam int LSB_LOW = 0;
    localparam int LSB_HIGH = 8;

    // per field: owning register and field position
    localparam logic [ADDR_W-1:0] FIELD_OFS [FIELD_CNT] = '{
        OFS_EXT_IRQ2, OFS_TIMER2, OFS_SERIAL2_CD, OFS_SERIAL2_CD, OFS_SERIAL2_SS, OFS_CAN_RX};
    localparam int FIELD_LSB [FIELD_CNT] = '{
        LSB_LOW, LSB_LOW, LSB_HIGH, LSB_LOW, LSB_LOW, LSB_LOW};

    // ==========================================================
    // AHB-Lite encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'h0;

endpackage : ris_pkg

`default_nettype wire

// ### inc/ris_sel_if.sv
/*
 * Carrier between the register side and one code multiplexer.
 * Assumes synchronised pin and comparator levels on the system clock.
 */
`default_nettype none

interface ris_sel_if;
    logic [ris_pkg::CODE_W-1:0] code;
    logic [ris_pkg::PIN_CNT-1:0] pins;
    logic cmp;
    logic routed;

    modport ctrl (output code, output pins, output cmp, input routed);
    modport mux (input code, input pins, input cmp, output routed);
endinterface : ris_sel_if

`default_nettype wire

// ### src/ris_code_mux.sv
/*
 * One selection-code multiplexer: ground, comparator or a remappable pin.
 * Assumes its pin and comparator levels are already synchronised.
 */
`default_nettype none

module ris_code_mux #(
    parameter logic [ris_pkg::PIN_CNT-1:0] CODE_VALID = {6'h00, {120{1'b1}}, 2'h0}
) (
    // selection carrier
    ris_sel_if.mux sel
);

    // ==========================================================
    // decode
    wire is_gnd = (sel.code == ris_pkg::CODE_GND);
    wire is_cmp = (sel.code == ris_pkg::CODE_CMP);
    // unlisted codes read as ground so a stray code never floats the input
    wire pin_lvl = CODE_VALID[sel.code] & sel.pins[sel.code];

    assign sel.routed = is_gnd ? 1'b0 : (is_cmp ? sel.cmp : pin_lvl);

endmodule : ris_code_mux

`default_nettype wire

// ### src/ris_top.sv
/*
 * Remappable input selector with an AHB-Lite register slave.
 * Routes a chosen pin, comparator 1 or ground to six peripheral inputs.
 * Assumes pins and comparator are asynchronous to hclk; single word transfers.
 */
`default_nettype none

// Contract
// - The external interrupt 2 input follows the source picked by bits 6..0 of its select register.
// - The timer 2 external clock input follows the source picked by bits 6..0 of its select register.
// - One register holds the serial 2 clock code in bits 14..8 and its data-in code in bits 6..0.
// - The serial 2 slave-select input follows the source picked by bits 6..0 of its select register.
// - The CAN receive input follows the source picked by bits 6..0 of its select register.
// - Code 1111001 connects the controlled input to remappable input pin 121.
// - Code 0000001 connects the controlled input to the comparator 1 output.
// - Code 0000000 holds the controlled input low.
// - Bits outside the selection fields read as zero and ignore writes.
module ris_top #(
    parameter logic [ris_pkg::PIN_CNT-1:0] CODE_VALID = {6'h00, {120{1'b1}}, 2'h0}
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // pin side
    input wire logic [ris_pkg::PIN_CNT-1:0] remappable_pin,
    input wire logic comparator_one_output,
    // routed peripheral inputs
    output logic external_interrupt_two,
    output logic timer_two_ext_clock,
    output logic serial_two_clock_in,
    output logic serial_two_data_in,
    output logic serial_two_slave_select,
    output logic can_receive_input
);

    // ==========================================================
    // address phase decode
    wire ap_take = hsel & hready & htrans[1];
    wire ap_mapped = (haddr[31:ris_pkg::ADDR_W] == 24'h000000) & (haddr[1:0] == 2'h0);
    wire ap_word = (hsize == ris_pkg::HSIZE_WORD);

    logic dp_write_r;
    logic dp_read_r;
    logic [ris_pkg::ADDR_W-1:0] dp_addr_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write_r <= 1'b0;
            dp_read_r <= 1'b0;
            dp_addr_r <= 8'h00;
        end else if (hready) begin
            // unmapped or narrow writes are dropped here, answered OKAY
            dp_write_r <= ap_take & hwrite & ap_mapped & ap_word;
            dp_read_r <= ap_take & ~hwrite;
            dp_addr_r <= ap_mapped ? haddr[ris_pkg::ADDR_W-1:0] : 8'hFF;
        end
    end

    // zero wait states: every transfer completes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp = ris_pkg::HRESP_OKAY;

    // ==========================================================
    // selection fields
    logic [ris_pkg::CODE_W-1:0] field_r [ris_pkg::FIELD_CNT];
    logic [ris_pkg::FIELD_CNT-1:0] field_hit;

    genvar gf;
    generate
        for (gf = 0; gf < ris_pkg::FIELD_CNT; gf++) begin : g_field
            assign field_hit[gf] = dp_write_r & (dp_addr_r == ris_pkg::FIELD_OFS[gf]);

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    field_r[gf] <= ris_pkg::FIELD_RESET;
                end else if (field_hit[gf]) begin
                    // only the field bits are stored; the rest of the word is dropped
                    field_r[gf] <= hwdata[ris_pkg::FIELD_LSB[gf] +: ris_pkg::CODE_W];
                end
            end
        end
    endgenerate

    // ==========================================================
    // read back
    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h00000000;
        for (int f = 0; f < ris_pkg::FIELD_CNT; f++) begin
            if (dp_addr_r == ris_pkg::FIELD_OFS[f]) begin
                // fields land at their own positions, all other bits stay zero
                rd_word[ris_pkg::FIELD_LSB[f] +: ris_pkg::CODE_W] = field_r[f];
            end
        end
    end

    assign hrdata = dp_read_r ? rd_word : 32'h00000000;

    // ==========================================================
    // pin and comparator synchronisers
    logic [ris_pkg::PIN_CNT-1:0] pin_meta_r;
    logic [ris_pkg::PIN_CNT-1:0] pin_sync_r;
    logic cmp_meta_r;
    logic cmp_sync_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
            cmp_meta_r <= 1'b0;
            cmp_sync_r <= 1'b0;
        end else begin
            pin_meta_r <= remappable_pin;
            pin_sync_r <= pin_meta_r;
            cmp_meta_r <= comparator_one_output;
            cmp_sync_r <= cmp_meta_r;
        end
    end

    // ==========================================================
    // code multiplexers and output flops
    ris_sel_if sel [ris_pkg::FIELD_CNT] ();
    logic [ris_pkg::FIELD_CNT-1:0] route_nxt;
    logic [ris_pkg::FIELD_CNT-1:0] route_r;

    generate
        for (gf = 0; gf < ris_pkg::FIELD_CNT; gf++) begin : g_route
            assign sel[gf].code = field_r[gf];
            assign sel[gf].pins = pin_sync_r;
            assign sel[gf].cmp = cmp_sync_r;

            // pin table is a parameter so each package option can prune codes
            ris_code_mux #(
                .CODE_VALID(CODE_VALID)
            ) u_mux (
                .sel(sel[gf])
            );

            assign route_nxt[gf] = sel[gf].routed;
        end
    endgenerate

    // one flop bank for all outputs, so every bit has a single writer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            route_r <= '0;
        end else begin
            route_r <= route_nxt;
        end
    end

    assign external_interrupt_two = route_r[ris_pkg::F_EXT_IRQ2];
    assign timer_two_ext_clock = route_r[ris_pkg::F_TIMER2_CLK];
    assign serial_two_clock_in = route_r[ris_pkg::F_SERIAL2_CLK];
    assign serial_two_data_in = route_r[ris_pkg::F_SERIAL2_DATA];
    assign serial_two_slave_select = route_r[ris_pkg::F_SERIAL2_SEL];
    assign can_receive_input = route_r[ris_pkg::F_CAN_RX];

    // ==========================================================
    // checks
    logic first_cyc_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_cyc_r <= 1'b1;
        end else begin
            first_cyc_r <= 1'b0;
        end
    end

    property p_ext_irq2_write;
        @(posedge hclk) disable iff (!hresetn)
        dp_write_r && dp_addr_r == ris_pkg::OFS_EXT_IRQ2
        |=> field_r[ris_pkg::F_EXT_IRQ2] == $past(hwdata[6:0]) ##2 external_interrupt_two ==
            $past(route_nxt[ris_pkg::F_EXT_IRQ2]);
    endproperty
    a_ext_irq2_write: assert property (p_ext_irq2_write) else $error("irq2 field or output wrong");

    property p_timer2_write;
        @(posedge hclk) disable iff (!hresetn)
        dp_write_r && dp_addr_r == ris_pkg::OFS_TIMER2
        |=> field_r[ris_pkg::F_TIMER2_CLK] == $past(hwdata[6:0]);
    endproperty
    a_timer2_write: assert property (p_timer2_write) else $error("timer2 field not written");

    property p_serial2_pair;
        @(posedge hclk) disable iff (!hresetn)
        dp_write_r && dp_addr_r == ris_pkg::OFS_SERIAL2_CD
        |=> field_r[ris_pkg::F_SERIAL2_CLK] == $past(hwdata[14:8])
            && field_r[ris_pkg::F_SERIAL2_DATA] == $past(hwdata[6:0]);
    endproperty
    a_serial2_pair: assert property (p_serial2_pair) else $error("serial2 clock/data fields wrong");

    property p_serial2_sel_write;
        @(posedge hclk) disable iff (!hresetn)
        dp_write_r && dp_addr_r == ris_pkg::OFS_SERIAL2_SS
        |=> field_r[ris_pkg::F_SERIAL2_SEL] == $past(hwdata[6:0]);
    endproperty
    a_serial2_sel_write: assert property (p_serial2_sel_write) else $error("serial2 select field wrong");

    property p_can_write;
        @(posedge hclk) disable iff (!hresetn)
        dp_write_r && dp_addr_r == ris_pkg::OFS_CAN_RX
        |=> field_r[ris_pkg::F_CAN_RX] == $past(hwdata[6:0]);
    endproperty
    a_can_write: assert property (p_can_write) else $error("can receive field wrong");

    property p_reserved_zero;
        @(posedge hclk) disable iff (!hresetn)
        dp_read_r |-> hrdata[31:15] == 17'h00000 && hrdata[7] == 1'b0
            && (dp_addr_r == ris_pkg::OFS_SERIAL2_CD || hrdata[14:8] == 7'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

    property p_reset_clear;
        @(posedge hclk) disable iff (!hresetn)
        first_cyc_r |-> field_r[0] == 7'h00 && field_r[5] == 7'h00 && route_r == 6'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("fields not clear after reset");

    // ==========================================================
    // bus checks
    property p_bus_okay;
        @(posedge hclk) disable iff (!hresetn)
        hreadyout && hresp == ris_pkg::HRESP_OKAY;
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus answer not zero-wait okay");

    property p_write_take;
        @(posedge hclk) disable iff (!hresetn)
        ap_take && hwrite && ap_mapped && ap_word
        |=> dp_write_r;
    endproperty
    a_write_take: assert property (p_write_take) else $error("word write not taken");

    property p_narrow_drop;
        @(posedge hclk) disable iff (!hresetn)
        ap_take && hwrite && !ap_word
        |=> !dp_write_r;
    endproperty
    a_narrow_drop: assert property (p_narrow_drop) else $error("narrow write stored");

    property p_unmapped_drop;
        @(posedge hclk) disable iff (!hresetn)
        ap_take && hwrite && !ap_mapped
        |=> !dp_write_r;
    endproperty
    a_unmapped_drop: assert property (p_unmapped_drop) else $error("unmapped write stored");

    property p_read_take;
        @(posedge hclk) disable iff (!hresetn)
        ap_take && !hwrite
        |=> dp_read_r;
    endproperty
    a_read_take: assert property (p_read_take) else $error("read not taken");

    property p_unmapped_read;
        @(posedge hclk) disable iff (!hresetn)
        dp_read_r && !$past(ap_mapped)
        |-> hrdata == 32'h00000000;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read nonzero");

    property p_idle_rdata;
        @(posedge hclk) disable iff (!hresetn)
        !dp_read_r
        |-> hrdata == 32'h00000000;
    endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside a read");

    // ==========================================================
    // routing, read-back and field hold checks
    generate
        for (gf = 0; gf < ris_pkg::FIELD_CNT; gf++) begin : g_chk
            property p_route_top;
                @(posedge hclk) disable iff (!hresetn)
                field_r[gf] == ris_pkg::CODE_TOP |=> route_r[gf] == $past(pin_sync_r[ris_pkg::TOP_PIN]);
            endproperty
            a_route_top: assert property (p_route_top) else $error("top code not on pin 121");

            property p_route_cmp;
                @(posedge hclk) disable iff (!hresetn)
                field_r[gf] == ris_pkg::CODE_CMP |=> route_r[gf] == $past(cmp_sync_r);
            endproperty
            a_route_cmp: assert property (p_route_cmp) else $error("comparator code not routed");

            property p_route_gnd;
                @(posedge hclk) disable iff (!hresetn)
                (field_r[gf] == ris_pkg::CODE_GND) [*2] |-> route_r[gf] == 1'b0;
            endproperty
            a_route_gnd: assert property (p_route_gnd) else $error("ground code not low");

            property p_route_table;
                @(posedge hclk) disable iff (!hresetn)
                field_r[gf] > ris_pkg::CODE_CMP
                |=> route_r[gf] == (CODE_VALID[$past(field_r[gf])] & $past(pin_sync_r[field_r[gf]]));
            endproperty
            a_route_table: assert property (p_route_table) else $error("pin code routed wrong");

            property p_read_field;
                @(posedge hclk) disable iff (!hresetn)
                dp_read_r && dp_addr_r == ris_pkg::FIELD_OFS[gf]
                |-> hrdata[ris_pkg::FIELD_LSB[gf] +: ris_pkg::CODE_W] == field_r[gf];
            endproperty
            a_read_field: assert property (p_read_field) else $error("field not read back in place");

            property p_field_hold;
                @(posedge hclk) disable iff (!hresetn)
                !field_hit[gf]
                |=> $stable(field_r[gf]);
            endproperty
            a_field_hold: assert property (p_field_hold) else $error("field changed without a write");

            // three edges from pin to output: two sync flops and the output flop
            property p_cmp_path;
                @(posedge hclk) disable iff (!hresetn)
                (field_r[gf] == ris_pkg::CODE_CMP) [*4]
                |-> route_r[gf] == $past(comparator_one_output, 3);
            endproperty
            a_cmp_path: assert property (p_cmp_path) else $error("comparator level not passed through");

            property p_top_path;
                @(posedge hclk) disable iff (!hresetn)
                (field_r[gf] == ris_pkg::CODE_TOP) [*4]
                |-> route_r[gf] == $past(remappable_pin[ris_pkg::TOP_PIN], 3);
            endproperty
            a_top_path: assert property (p_top_path) else $error("pin 121 level not passed through");
        end
    endgenerate

endmodule : ris_top

`default_nettype wire

// ### tb/ris_tb.sv
/*
 * Self-checking bench for the remappable input selector top.
 * Assumes the package and interface are compiled first; drives AHB-Lite itself.
 */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // stimulus and observed signals
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [ris_pkg::PIN_CNT-1:0] pins = '0;
    logic cmp = 1'b0;
    wire logic hready;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic [5:0] routed;
    int n_errors = 0;
    int compares = 0;
    logic [31:0] rd;
    logic [7:0] regs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};

    always #2.5 hclk = ~hclk;

    ris_top u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .remappable_pin(pins), .comparator_one_output(cmp),
        .external_interrupt_two(routed[0]), .timer_two_ext_clock(routed[1]),
        .serial_two_clock_in(routed[2]), .serial_two_data_in(routed[3]),
        .serial_two_slave_select(routed[4]), .can_receive_input(routed[5])
    );

    // ==========================================================
    // helpers
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // ready and read data are taken at the rising edge, before that edge's updates land
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        if (hready !== 1'b1) chk("ready wait", 32'h1, 32'h0);
        rd = hrdata;
        chk("hresp", {31'h0, ris_pkg::HRESP_OKAY}, {31'h0, hresp});
    endtask : wait_ready

    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, input logic [2:0] sz);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        hsize <= sz;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
    endtask : xfer

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, ris_pkg::HSIZE_WORD);
        chk($sformatf("read %h", a), exp, rd);
    endtask : rd_chk

    // program one field, set the sources, then let sync plus output flop settle
    task automatic route(input int f, input logic [6:0] code, input logic [127:0] p, input logic c,
                         input logic exp);
        xfer(1'b1, {24'h0, ris_pkg::FIELD_OFS[f]}, 32'({code}) << ris_pkg::FIELD_LSB[f], ris_pkg::HSIZE_WORD);
        pins <= p;
        cmp <= c;
        repeat (5) @(posedge hclk);
        chk($sformatf("routed field %0d code %h", f, code), {31'h0, exp}, {31'h0, routed[f]});
    endtask : route

    task automatic conclude();
        $display("checks %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // ==========================================================
    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        #50000;
        n_errors++;
        conclude();
    end

    // ==========================================================
    // main sequence
    localparam logic [127:0] ONE = 128'h1;
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        pins <= '1;
        cmp <= 1'b1;
        repeat (4) @(posedge hclk);
        chk("routed after reset", 32'h0, {26'h0, routed});
        for (int i = 0; i < 5; i++) begin
            rd_chk({24'h0, regs[i]}, 32'h0);
        end
        // all ones: only the field bits may stick
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, {24'h0, regs[i]}, 32'hFFFF_FFFF, ris_pkg::HSIZE_WORD);
            rd_chk({24'h0, regs[i]}, (i == 2) ? 32'h0000_7F7F : 32'h0000_007F);
        end
        // narrow write is dropped, unmapped places read zero
        xfer(1'b1, 32'h0, 32'h0, 3'h0);
        rd_chk(32'h0, 32'h0000_007F);
        xfer(1'b1, 32'h14, 32'hFFFF_FFFF, ris_pkg::HSIZE_WORD);
        rd_chk(32'h14, 32'h0);
        rd_chk(32'h100, 32'h0);
        // every routed input through every special code, one ordinary pin and one unlisted code
        for (int f = 0; f < ris_pkg::FIELD_CNT; f++) begin
            route(f, ris_pkg::CODE_TOP, ONE << 121, 1'b0, 1'b1);
            route(f, ris_pkg::CODE_TOP, ~(ONE << 121), 1'b1, 1'b0);
            route(f, ris_pkg::CODE_CMP, '0, 1'b1, 1'b1);
            route(f, ris_pkg::CODE_CMP, '1, 1'b0, 1'b0);
            route(f, ris_pkg::CODE_GND, '1, 1'b1, 1'b0);
            route(f, 7'h05, ONE << 5, 1'b0, 1'b1);
            route(f, 7'h05, ~(ONE << 5), 1'b1, 1'b0);
            route(f, 7'h7A, '1, 1'b1, 1'b0);
        end
        // shared register: clock field on pin 121, data field on comparator
        xfer(1'b1, 32'h08, 32'h0000_7901, ris_pkg::HSIZE_WORD);
        pins <= ONE << 121;
        cmp <= 1'b0;
        repeat (5) @(posedge hclk);
        chk("serial clock in", 32'h1, {31'h0, routed[2]});
        chk("serial data in", 32'h0, {31'h0, routed[3]});
        rd_chk(32'h08, 32'h0000_7901);
        // reset in mid-run clears every field again
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        chk("routed after second reset", 32'h0, {26'h0, routed});
        rd_chk(32'h08, 32'h0);
        conclude();
    end
endmodule : tb

`default_nettype wire
